/* rtl/hmmr_modbus_regs.sv */
// Hydrogen monitor register bank behind a serial slave on an RS-485 line
`timescale 1ns/1ps

module hmmr_modbus_regs #(
	parameter int BIT_CYC = hmmr_pkg::CLK_HZ / hmmr_pkg::BAUD_DEFAULT,
	parameter int GAP_CYC = (BIT_CYC * hmmr_pkg::GAP_BITS_X10) / hmmr_pkg::GAP_DIV
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// RS-485 transceiver
	input  wire logic        rs485_rxd,
	output logic             rs485_txd,
	output logic             rs485_de,
	// Measurement system
	input  wire logic        startup_done,
	input  wire logic        meas_valid,
	input  wire logic [31:0] meas_ppm,
	input  wire logic [15:0] meas_temp,
	input  wire logic        sensor_fault,
	input  wire logic        transient_fault,
	input  wire logic [15:0] fault_code_first,
	input  wire logic [15:0] fault_code_second,
	output logic             meas_enable,
	// Status
	output logic             unit_ready,
	output logic             unit_error,
	output logic [15:0]      unit_address
);

	localparam int BW = $clog2(BIT_CYC + 1);

	if (BIT_CYC < hmmr_pkg::MIN_BIT_CYC || GAP_CYC <= BIT_CYC) begin : g_bad_timing
		$error("Bit or gap cycle count too small");
	end

	typedef enum logic [1:0] {S_IDLE, S_EXEC, S_LOAD, S_SHIFT} hmmr_state_t;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	hmmr_state_t   state_reg;
	logic [7:0]    rx_buf [hmmr_pkg::RX_LEN];
	logic [3:0]    rx_cnt_reg;
	logic          rx_bad_reg;
	logic [15:0]   rx_crc_reg;
	logic [31:0]   ppm_reg;
	logic [15:0]   temp_reg;
	logic [15:0]   low_latch_reg;
	logic          ready_reg;
	logic          err_reg;
	logic          dead_reg;
	logic          meas_run_reg;
	logic [15:0]   detail1_reg;
	logic [15:0]   detail2_reg;
	logic [15:0]   unit_addr_reg;
	logic [7:0]    exc_reg;
	logic [7:0]    resp_len_reg;
	logic [7:0]    tx_idx_reg;
	logic [15:0]   rd_addr_reg;
	logic [7:0]    word_hold_reg;
	logic [15:0]   tx_crc_reg;
	logic [8:0]    tx_shift_reg;
	logic [3:0]    tx_bits_reg;
	logic [BW-1:0] tx_cnt_reg;
	logic          txd_reg;
	logic          de_reg;

	logic          rx_valid;
	logic [7:0]    rx_data;
	logic          rx_ferr;
	logic          rx_gap;
	logic [15:0]   rx_crc_next;
	logic [15:0]   tx_crc_next;
	logic [7:0]    tx_byte;
	logic [15:0]   rd_word;
	logic [15:0]   status_word;

	// ----------------------------------------------------------------
	// Receive path
	// ----------------------------------------------------------------
	hmmr_uart_rx #(
		.BIT_CYC (BIT_CYC),
		.GAP_CYC (GAP_CYC)
	) u_rx (
		.clk        (clk),
		.rst        (rst),
		.rxd        (rs485_rxd),
		.byte_valid (rx_valid),
		.byte_data  (rx_data),
		.frame_err  (rx_ferr),
		.gap_seen   (rx_gap)
	);

	hmmr_crc16 u_rx_crc (
		.crc_in  (rx_crc_reg),
		.data    (rx_data),
		.crc_out (rx_crc_next)
	);

	// Frames arriving while a reply is pending are dropped (half duplex)
	wire rx_take = rx_valid && (state_reg == S_IDLE);
	wire rx_full = (rx_cnt_reg == hmmr_pkg::RX_LEN);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_cnt_reg <= '0;
			rx_bad_reg <= 1'b0;
			rx_crc_reg <= hmmr_pkg::CRC_INIT;
		end else if (rx_gap) begin
			rx_cnt_reg <= '0;
			rx_bad_reg <= 1'b0;
			rx_crc_reg <= hmmr_pkg::CRC_INIT;
		end else if (rx_take) begin
			rx_bad_reg <= rx_bad_reg || rx_full || rx_ferr;
			rx_cnt_reg <= rx_full ? rx_cnt_reg : rx_cnt_reg + 1'b1;
			rx_crc_reg <= rx_crc_next;
		end
	end

	always_ff @(posedge clk) begin
		if (rx_take && !rx_full) rx_buf[rx_cnt_reg[2:0]] <= rx_data;
	end

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------
	wire [7:0]  fc        = rx_buf[1];
	wire [15:0] start     = {rx_buf[2], rx_buf[3]};
	wire [15:0] wr_value  = {rx_buf[4], rx_buf[5]};
	wire        bcast     = (rx_buf[0] == hmmr_pkg::BCAST_ADDR);
	wire        addr_hit  = (rx_buf[0] == unit_addr_reg[7:0]) || bcast;
	wire        frame_go  = rx_gap && !rx_bad_reg && (rx_cnt_reg == hmmr_pkg::RX_LEN)
	                        && (rx_crc_reg == 16'h0000) && addr_hit && (state_reg == S_IDLE);
	wire        is_read   = (fc == hmmr_pkg::FC_READ_HOLD) || (fc == hmmr_pkg::FC_READ_INPUT);
	wire        is_write  = (fc == hmmr_pkg::FC_WRITE_SINGLE);
	wire        cnt_ok    = (wr_value != 16'h0000) && (wr_value <= hmmr_pkg::READ_MAX);
	wire        mapped    = (start == hmmr_pkg::REG_H2_HIGH) || (start == hmmr_pkg::REG_H2_LOW)
	                        || (start == hmmr_pkg::REG_LIQ_TEMP) || (start == hmmr_pkg::REG_STATUS)
	                        || (start == hmmr_pkg::REG_ERR_FIRST)
	                        || (start == hmmr_pkg::REG_ERR_SECOND)
	                        || (start == hmmr_pkg::REG_UNIT_ADDR);
	wire        wr_val_ok = (wr_value >= hmmr_pkg::UNIT_ADDR_MIN)
	                        && (wr_value <= hmmr_pkg::UNIT_ADDR_MAX);
	wire [7:0]  exc_code  = (!is_read && !is_write) ? hmmr_pkg::EXC_ILL_FUNC :
	                        (is_read && !cnt_ok) ? hmmr_pkg::EXC_ILL_VALUE :
	                        (is_read && !mapped) ? hmmr_pkg::EXC_ILL_ADDR :
	                        (is_write && start != hmmr_pkg::REG_UNIT_ADDR) ? hmmr_pkg::EXC_ILL_ADDR :
	                        (is_write && !wr_val_ok) ? hmmr_pkg::EXC_ILL_VALUE :
	                        hmmr_pkg::EXC_NONE;
	wire        wr_apply  = is_write && (exc_code == hmmr_pkg::EXC_NONE);
	wire [7:0]  byte_cnt  = {wr_value[6:0], 1'b0};
	wire [7:0]  resp_len  = (exc_code != hmmr_pkg::EXC_NONE) ? hmmr_pkg::EXC_LEN :
	                        is_read ? 8'(hmmr_pkg::READ_OVH + byte_cnt) : hmmr_pkg::WRITE_LEN;

	// ----------------------------------------------------------------
	// Measurement, status and fault handling
	// ----------------------------------------------------------------
	wire dead_now = dead_reg || sensor_fault;
	wire err_now  = dead_now || transient_fault;
	wire accept   = startup_done && meas_valid && !dead_now && !transient_fault;
	wire [15:0] ppm_low = ppm_reg[15:0];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dead_reg     <= 1'b0;
			meas_run_reg <= 1'b1;
			err_reg      <= 1'b0;
			detail1_reg  <= '0;
			detail2_reg  <= '0;
		end else begin
			dead_reg     <= dead_now;
			meas_run_reg <= !dead_now;
			err_reg      <= err_now;
			detail1_reg  <= err_now ? fault_code_first : '0;
			detail2_reg  <= err_now ? fault_code_second : '0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ppm_reg   <= '0;
			temp_reg  <= '0;
			ready_reg <= 1'b0;
		end else if (accept) begin
			ppm_reg   <= meas_ppm;
			temp_reg  <= meas_temp;
			ready_reg <= 1'b1;
		end
	end

	always_comb begin
		status_word                           = 16'h0000;
		status_word[hmmr_pkg::STAT_READY_BIT] = ready_reg;
		status_word[hmmr_pkg::STAT_ERROR_BIT] = err_reg;
	end

	always_comb begin
		case (rd_addr_reg)
			hmmr_pkg::REG_H2_HIGH:    rd_word = ppm_reg[31:16];
			hmmr_pkg::REG_H2_LOW:     rd_word = low_latch_reg;
			hmmr_pkg::REG_LIQ_TEMP:   rd_word = temp_reg;
			hmmr_pkg::REG_STATUS:     rd_word = status_word;
			hmmr_pkg::REG_ERR_FIRST:  rd_word = detail1_reg;
			hmmr_pkg::REG_ERR_SECOND: rd_word = detail2_reg;
			hmmr_pkg::REG_UNIT_ADDR:  rd_word = unit_addr_reg;
			default:                  rd_word = 16'h0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Reply byte selection
	// ----------------------------------------------------------------
	wire       exc_on   = (exc_reg != hmmr_pkg::EXC_NONE);
	wire [7:0] body_len = resp_len_reg - hmmr_pkg::CRC_BYTES;
	wire [7:0] data_pos = tx_idx_reg - hmmr_pkg::DATA_POS;
	wire       in_data  = !exc_on && is_read && (tx_idx_reg >= hmmr_pkg::DATA_POS)
	                      && (tx_idx_reg < body_len);
	wire       fetch_hi = (state_reg == S_LOAD) && in_data && !data_pos[0];
	wire       fetch_lo = (state_reg == S_LOAD) && in_data && data_pos[0];
	wire       tx_last  = (tx_idx_reg == resp_len_reg - 8'h01);
	wire       bit_end  = (tx_cnt_reg == BW'(BIT_CYC - 1));

	always_comb begin
		if (tx_idx_reg >= body_len)
			tx_byte = (tx_idx_reg == body_len) ? tx_crc_reg[7:0] : tx_crc_reg[15:8];
		else if (exc_on)
			tx_byte = (tx_idx_reg == 8'h00) ? rx_buf[0] :
			          (tx_idx_reg == 8'h01) ? (rx_buf[1] | hmmr_pkg::EXC_FLAG) : exc_reg;
		else if (in_data)
			tx_byte = data_pos[0] ? word_hold_reg : rd_word[15:8];
		else if (is_read && tx_idx_reg == hmmr_pkg::COUNT_POS)
			tx_byte = byte_cnt;
		else
			tx_byte = rx_buf[tx_idx_reg[2:0]];
	end

	hmmr_crc16 u_tx_crc (
		.crc_in  (tx_crc_reg),
		.data    (tx_byte),
		.crc_out (tx_crc_next)
	);

	// ----------------------------------------------------------------
	// Request execution and unit address
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			exc_reg       <= hmmr_pkg::EXC_NONE;
			resp_len_reg  <= hmmr_pkg::EXC_LEN;
			unit_addr_reg <= hmmr_pkg::UNIT_ADDR_RST;
		end else if (state_reg == S_EXEC) begin
			exc_reg      <= exc_code;
			resp_len_reg <= resp_len;
			if (wr_apply) unit_addr_reg <= wr_value;
		end
	end

	// Word fetch; reading the high ppm word snapshots the low word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_addr_reg   <= '0;
			word_hold_reg <= '0;
			low_latch_reg <= '0;
		end else begin
			if (state_reg == S_EXEC) rd_addr_reg <= start;
			if (fetch_lo) rd_addr_reg <= rd_addr_reg + 16'h0001;
			if (fetch_hi) word_hold_reg <= rd_word[7:0];
			if (fetch_hi && rd_addr_reg == hmmr_pkg::REG_H2_HIGH)
				low_latch_reg <= ppm_low;
		end
	end

	// ----------------------------------------------------------------
	// Frame sequencing and serial transmit
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg    <= S_IDLE;
			tx_idx_reg   <= '0;
			tx_crc_reg   <= hmmr_pkg::CRC_INIT;
			tx_shift_reg <= '1;
			tx_bits_reg  <= '0;
			tx_cnt_reg   <= '0;
			txd_reg      <= 1'b1;
			de_reg       <= 1'b0;
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (frame_go) state_reg <= S_EXEC;
				end
				S_EXEC: begin
					tx_idx_reg <= '0;
					tx_crc_reg <= hmmr_pkg::CRC_INIT;
					state_reg  <= bcast ? S_IDLE : S_LOAD;
				end
				S_LOAD: begin
					tx_shift_reg <= {1'b1, tx_byte};
					txd_reg      <= 1'b0;
					de_reg       <= 1'b1;
					tx_bits_reg  <= '0;
					tx_cnt_reg   <= '0;
					if (tx_idx_reg < body_len) tx_crc_reg <= tx_crc_next;
					state_reg    <= S_SHIFT;
				end
				S_SHIFT: begin
					tx_cnt_reg <= bit_end ? '0 : tx_cnt_reg + 1'b1;
					if (bit_end && tx_bits_reg == hmmr_pkg::UART_LAST_BIT) begin
						tx_idx_reg <= tx_idx_reg + 8'h01;
						de_reg     <= !tx_last;
						state_reg  <= tx_last ? S_IDLE : S_LOAD;
					end else if (bit_end) begin
						txd_reg      <= tx_shift_reg[0];
						tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
						tx_bits_reg  <= tx_bits_reg + 4'h1;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	assign rs485_txd    = txd_reg;
	assign rs485_de     = de_reg;
	assign meas_enable  = meas_run_reg;
	assign unit_ready   = ready_reg;
	assign unit_error   = err_reg;
	assign unit_address = unit_addr_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_ready_cause: assert property (@(posedge clk) disable iff (rst)
		$rose(ready_reg) |-> $past(meas_valid) && $past(startup_done))
		else $error("Ready set without a valid measurement");
	a_values_gated: assert property (@(posedge clk) disable iff (rst)
		!ready_reg |-> (ppm_reg == 32'h0000_0000) && (temp_reg == 16'h0000))
		else $error("Values visible before first measurement");
	a_addr_write: assert property (@(posedge clk) disable iff (rst)
		(state_reg == S_EXEC) && wr_apply |=> unit_addr_reg == $past(wr_value))
		else $error("Unit address not taken from write");
	a_addr_stable: assert property (@(posedge clk) disable iff (rst)
		(state_reg != S_EXEC) |=> $stable(unit_addr_reg))
		else $error("Unit address changed without a write");
	a_fault_flag: assert property (@(posedge clk) disable iff (rst)
		sensor_fault |=> err_reg && !meas_run_reg ##1 err_reg && !meas_run_reg)
		else $error("Sensor fault not reported or measuring not stopped");
	a_detail_zero: assert property (@(posedge clk) disable iff (rst)
		!err_reg |-> (detail1_reg == 16'h0000) && (detail2_reg == 16'h0000))
		else $error("Error detail nonzero without error flag");
	a_low_latch: assert property (@(posedge clk) disable iff (rst)
		fetch_hi && (rd_addr_reg == hmmr_pkg::REG_H2_HIGH) |=> low_latch_reg == $past(ppm_low))
		else $error("Low ppm word not latched on high read");
	a_dead_holds: assert property (@(posedge clk) disable iff (rst)
		dead_reg |=> dead_reg && unit_error)
		else $error("Dead sensor state lost");
	a_recover: assert property (@(posedge clk) disable iff (rst)
		!dead_reg && !sensor_fault && !transient_fault && $past(transient_fault) |=> !err_reg)
		else $error("No recovery after transient fault");
	a_drive_start: assert property (@(posedge clk) disable iff (rst)
		!txd_reg |-> de_reg)
		else $error("Line driven low while driver disabled");

endmodule

/* rtl/hmmr_pkg.sv */
// Shared constants of the hydrogen monitor register bank
package hmmr_pkg;

	// ----------------------------------------------------------------
	// Clock and line timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ       = 100_000_000;
	localparam int BAUD_DEFAULT = 9600;
	localparam int GAP_BITS_X10 = 385;
	localparam int GAP_DIV      = 10;
	localparam int MIN_BIT_CYC  = 8;

	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [15:0] REG_H2_HIGH    = 16'h0000;
	localparam logic [15:0] REG_H2_LOW     = 16'h0001;
	localparam logic [15:0] REG_LIQ_TEMP   = 16'h0008;
	localparam logic [15:0] REG_STATUS     = 16'h006F;
	localparam logic [15:0] REG_ERR_FIRST  = 16'h0070;
	localparam logic [15:0] REG_ERR_SECOND = 16'h0071;
	localparam logic [15:0] REG_UNIT_ADDR  = 16'h0096;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int          STAT_READY_BIT = 15;
	localparam int          STAT_ERROR_BIT = 12;
	localparam logic [15:0] UNIT_ADDR_RST  = 16'h0001;
	localparam logic [15:0] UNIT_ADDR_MIN  = 16'h0001;
	localparam logic [15:0] UNIT_ADDR_MAX  = 16'h00F7;
	localparam logic [7:0]  BCAST_ADDR     = 8'h00;

	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam logic [7:0]  FC_READ_HOLD    = 8'h03;
	localparam logic [7:0]  FC_READ_INPUT   = 8'h04;
	localparam logic [7:0]  FC_WRITE_SINGLE = 8'h06;
	localparam logic [7:0]  EXC_FLAG        = 8'h80;
	localparam logic [7:0]  EXC_NONE        = 8'h00;
	localparam logic [7:0]  EXC_ILL_FUNC    = 8'h01;
	localparam logic [7:0]  EXC_ILL_ADDR    = 8'h02;
	localparam logic [7:0]  EXC_ILL_VALUE   = 8'h03;
	localparam logic [15:0] READ_MAX        = 16'h007D;
	localparam logic [3:0]  RX_LEN          = 4'h8;
	localparam logic [7:0]  EXC_LEN         = 8'h05;
	localparam logic [7:0]  WRITE_LEN       = 8'h08;
	localparam logic [7:0]  READ_OVH        = 8'h05;
	localparam logic [7:0]  CRC_BYTES       = 8'h02;
	localparam logic [7:0]  DATA_POS        = 8'h03;
	localparam logic [7:0]  COUNT_POS       = 8'h02;
	localparam logic [15:0] CRC_INIT        = 16'hFFFF;
	localparam logic [15:0] CRC_POLY        = 16'hA001;
	localparam logic [3:0]  UART_LAST_BIT   = 4'h9;
	localparam logic [2:0]  RX_LAST_DATA    = 3'h7;

endpackage

/* rtl/hmmr_crc16.sv */
// One byte step of the reflected CRC-16 used on the serial frames
`timescale 1ns/1ps

module hmmr_crc16 (
	// Running value and byte
	input  wire logic [15:0] crc_in,
	input  wire logic [7:0]  data,
	// Updated value
	output logic      [15:0] crc_out
);

	logic [15:0] c;

	always_comb begin
		c = crc_in ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ hmmr_pkg::CRC_POLY) : (c >> 1);
		end
		crc_out = c;
	end

endmodule

/* rtl/hmmr_uart_rx.sv */
// Serial byte receiver with end-of-frame silence detection
`timescale 1ns/1ps

module hmmr_uart_rx #(
	parameter int BIT_CYC = 10416,
	parameter int GAP_CYC = 401016
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Line
	input  wire logic       rxd,
	// Received byte
	output logic            byte_valid,
	output logic [7:0]      byte_data,
	output logic            frame_err,
	output logic            gap_seen
);

	localparam int BW = $clog2(BIT_CYC + 1);
	localparam int GW = $clog2(GAP_CYC + 1);

	typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_STOP} hmmr_rx_state_t;

	hmmr_rx_state_t state_reg;
	logic [BW-1:0]  cnt_reg;
	logic [2:0]     bit_reg;
	logic [7:0]     shift_reg;
	logic [GW-1:0]  gap_reg;
	logic           armed_reg;
	wire            bit_end  = (cnt_reg == BW'(BIT_CYC - 1));
	wire            half_end = (cnt_reg == BW'(BIT_CYC / 2 - 1));

	// ----------------------------------------------------------------
	// Character framing
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg  <= R_IDLE;
			cnt_reg    <= '0;
			bit_reg    <= '0;
			shift_reg  <= '0;
			byte_valid <= 1'b0;
			byte_data  <= '0;
			frame_err  <= 1'b0;
		end else begin
			byte_valid <= 1'b0;
			cnt_reg    <= bit_end ? '0 : cnt_reg + 1'b1;
			case (state_reg)
				R_IDLE: begin
					cnt_reg <= '0;
					if (!rxd) state_reg <= R_START;
				end
				R_START: begin
					if (half_end) begin
						cnt_reg   <= '0;
						bit_reg   <= '0;
						state_reg <= rxd ? R_IDLE : R_DATA;
					end
				end
				R_DATA: begin
					if (bit_end) begin
						shift_reg <= {rxd, shift_reg[7:1]};
						bit_reg   <= bit_reg + 1'b1;
						if (bit_reg == hmmr_pkg::RX_LAST_DATA) state_reg <= R_STOP;
					end
				end
				R_STOP: begin
					if (bit_end) begin
						byte_valid <= 1'b1;
						byte_data  <= shift_reg;
						frame_err  <= !rxd;
						state_reg  <= R_IDLE;
					end
				end
				default: state_reg <= R_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Silence after the last character closes the frame
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gap_reg   <= '0;
			armed_reg <= 1'b0;
			gap_seen  <= 1'b0;
		end else begin
			gap_seen <= 1'b0;
			if (state_reg != R_IDLE || !rxd) begin
				gap_reg   <= '0;
				armed_reg <= 1'b1;
			end else if (armed_reg) begin
				gap_reg <= gap_reg + 1'b1;
				if (gap_reg == GW'(GAP_CYC - 1)) begin
					gap_seen  <= 1'b1;
					armed_reg <= 1'b0;
				end
			end
		end
	end

endmodule

/* verification/hmmr_master_model.sv */
// Serial master model that frames requests and collects replies
`timescale 1ns/1ps

module hmmr_master_model #(
	parameter int BIT_CYC = 16
) (
	// Clock
	input  wire logic clk,
	// Line
	input  wire logic txd,
	output logic      rxd
);
	logic [7:0] rx_q[$];
	logic [7:0] rx_byte;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
		return r;
	endfunction

	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd = f[i];
			repeat (BIT_CYC) @(negedge clk);
		end
	endtask

	task automatic send_req(input logic [7:0] a, input logic [7:0] fc, input logic [15:0] r,
		input logic [15:0] v);
		logic [7:0]  b[6];
		logic [15:0] c;
		b = '{a, fc, r[15:8], r[7:0], v[15:8], v[7:0]};
		c = 16'hffff;
		for (int i = 0; i < 6; i++) begin
			c = crc_step(c, b[i]);
			send_byte(b[i]);
		end
		send_byte(c[7:0]);
		send_byte(c[15:8]);
	endtask

	// Reply bytes sampled in mid-bit
	initial begin
		rxd = 1'b1;
		forever begin
			@(negedge txd);
			repeat (BIT_CYC / 2) @(negedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(negedge clk);
				rx_byte[i] = txd;
			end
			repeat (BIT_CYC) @(negedge clk);
			rx_q.push_back(rx_byte);
		end
	end
endmodule

/* verification/testbench.sv */
// Self-checking bench for the hydrogen monitor register bank
`timescale 1ns/1ps

module testbench;
	logic        clk;
	logic        rst;
	logic        rs485_rxd;
	logic        rs485_txd;
	logic        rs485_de;
	logic [15:0] fault_code_first;
	logic [15:0] fault_code_second;
	logic        startup_done;
	logic        meas_valid;
	logic [31:0] meas_ppm;
	logic [15:0] meas_temp;
	logic        sensor_fault;
	logic        transient_fault;
	logic        meas_enable;
	logic        unit_ready;
	logic        unit_error;
	logic [15:0] unit_address;
	logic [7:0]  uid;
	int          failures;
	int          samples_checked;

	hmmr_modbus_regs #(.BIT_CYC(16), .GAP_CYC(620)) dut (.clk, .rst, .rs485_rxd, .rs485_txd,
		.rs485_de, .startup_done, .meas_valid, .meas_ppm, .meas_temp, .sensor_fault,
		.transient_fault, .fault_code_first, .fault_code_second,
		.meas_enable, .unit_ready, .unit_error, .unit_address);
	hmmr_master_model #(.BIT_CYC(16)) m (.clk, .txd(rs485_txd), .rxd(rs485_rxd));

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_flag(input string name, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic xfer(input logic [7:0] fc, input logic [15:0] r, input logic [15:0] v,
		input int n);
		logic [15:0] c;
		logic        go;
		int          de_low;
		go = 1'b0;
		de_low = 0;
		m.rx_q.delete();
		m.send_req(uid, fc, r, v);
		// Driver enable must stand from the first start bit to the last byte
		for (int i = 0; i < 6000 && m.rx_q.size() < n; i++) begin
			@(negedge clk);
			if (!rs485_txd) go = 1'b1;
			if (go && !rs485_de) de_low++;
		end
		repeat (40) @(negedge clk);
		chk("driver enable lapses", 16'h0000, 16'(de_low));
		chk_flag("driver enable idle", 1'b0, rs485_de);
		chk("reply length", 16'(n), 16'(m.rx_q.size()));
		c = 16'hffff;
		for (int i = 0; i + 2 < n; i++) c = m.crc_step(c, m.rx_q[i]);
		chk("reply crc", c, {m.rx_q[n - 1], m.rx_q[n - 2]});
	endtask

	task automatic rd(input logic [15:0] r, input int n, input logic [15:0] e0,
		input logic [15:0] e1, input logic [15:0] e2);
		logic [15:0] e[3];
		e = '{e0, e1, e2};
		xfer(8'h03, r, 16'(n), 5 + 2 * n);
		chk("byte count", 16'(2 * n), {8'h00, m.rx_q[2]});
		for (int k = 0; k < n; k++) chk("register", e[k], {m.rx_q[3 + 2 * k], m.rx_q[4 + 2 * k]});
	endtask

	task automatic pulse(input logic [31:0] p, input logic [15:0] t);
		meas_ppm = p;
		meas_temp = t;
		meas_valid = 1'b1;
		@(negedge clk);
		meas_valid = 1'b0;
		@(negedge clk);
	endtask

	task automatic t_startup;
		chk("unit address", 16'h0001, unit_address);
		pulse(32'h1234_5678, 16'h0077);
		chk_flag("ready", 1'b0, unit_ready);
		rd(16'h0000, 2, 16'h0000, 16'h0000, 16'h0000);
		startup_done = 1'b1;
		pulse(32'h0012_3456, 16'h0019);
		chk_flag("ready", 1'b1, unit_ready);
		rd(16'h006f, 1, 16'h8000, 16'h0000, 16'h0000);
		rd(16'h0008, 1, 16'h0019, 16'h0000, 16'h0000);
		rd(16'h0001, 1, 16'h0000, 16'h0000, 16'h0000);
		rd(16'h0000, 1, 16'h0012, 16'h0000, 16'h0000);
		rd(16'h0001, 1, 16'h3456, 16'h0000, 16'h0000);
	endtask

	task automatic t_transient;
		transient_fault = 1'b1;
		repeat (2) @(negedge clk);
		chk_flag("error", 1'b1, unit_error);
		rd(16'h006f, 3, 16'h9000, 16'h0a0b, 16'h0c0d);
		transient_fault = 1'b0;
		repeat (2) @(negedge clk);
		chk_flag("error", 1'b0, unit_error);
		chk_flag("measuring", 1'b1, meas_enable);
		rd(16'h006f, 3, 16'h8000, 16'h0000, 16'h0000);
	endtask

	task automatic t_unit_addr;
		xfer(8'h06, 16'h0096, 16'h0005, 8);
		chk("echo address", 16'h0001, {8'h00, m.rx_q[0]});
		chk("unit address", 16'h0005, unit_address);
		uid = 8'h05;
		rd(16'h0096, 1, 16'h0005, 16'h0000, 16'h0000);
	endtask

	task automatic t_exception;
		xfer(8'h02, 16'h0000, 16'h0001, 5);
		chk("exception", 16'h8201, {m.rx_q[1], m.rx_q[2]});
		xfer(8'h04, 16'h0002, 16'h0001, 5);
		chk("exception", 16'h8402, {m.rx_q[1], m.rx_q[2]});
		xfer(8'h03, 16'h0000, 16'h0000, 5);
		chk("exception", 16'h8303, {m.rx_q[1], m.rx_q[2]});
		xfer(8'h06, 16'h0008, 16'h0007, 5);
		chk("exception", 16'h8602, {m.rx_q[1], m.rx_q[2]});
		xfer(8'h06, 16'h0096, 16'h0000, 5);
		chk("exception", 16'h8603, {m.rx_q[1], m.rx_q[2]});
		chk("unit address", 16'h0005, unit_address);
		xfer(8'h04, 16'h0096, 16'h0001, 7);
		chk("register", 16'h0005, {m.rx_q[3], m.rx_q[4]});
	endtask

	task automatic t_reset;
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk_flag("measuring", 1'b1, meas_enable);
		chk_flag("error", 1'b0, unit_error);
		chk_flag("ready", 1'b0, unit_ready);
		chk("unit address", 16'h0001, unit_address);
	endtask

	task automatic t_sensor;
		fault_code_first = 16'h0e01;
		fault_code_second = 16'h0e02;
		sensor_fault = 1'b1;
		@(negedge clk);
		sensor_fault = 1'b0;
		@(negedge clk);
		chk_flag("measuring", 1'b0, meas_enable);
		pulse(32'h0000_0bad, 16'h0033);
		rd(16'h0000, 2, 16'h0012, 16'h3456, 16'h0000);
		rd(16'h006f, 3, 16'h9000, 16'h0e01, 16'h0e02);
	endtask

	task automatic results;
		if (failures == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		rst = 1'b1;
		startup_done = 1'b0;
		meas_valid = 1'b0;
		meas_ppm = 32'h0000_0000;
		meas_temp = 16'h0000;
		sensor_fault = 1'b0;
		transient_fault = 1'b0;
		fault_code_first = 16'h0a0b;
		fault_code_second = 16'h0c0d;
		uid = 8'h01;
		failures = 0;
		samples_checked = 0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (700) @(negedge clk);
		t_startup();
		t_transient();
		t_unit_addr();
		t_exception();
		t_sensor();
		t_reset();
		results();
	end

	// Watchdog against a hung transfer
	initial begin
		repeat (90000) @(negedge clk);
		failures++;
		results();
	end
endmodule
